// ---- cbalu_pkg.sv ----
package cbalu_pkg;

   localparam int XLEN    = 32;
   localparam int SH_W    = 5;
   localparam int COUNT_W = 6;

   typedef logic [XLEN-1:0] cbalu_word_t;
   typedef logic [SH_W-1:0] cbalu_shamt_t;
   typedef logic [COUNT_W-1:0] cbalu_count_t;

   // instruction field positions and widths
   localparam int OPC_LSB = 0;
   localparam int OPC_W   = 7;
   localparam int F3_LSB  = 12;
   localparam int F3_W    = 3;
   localparam int F7_LSB  = 25;
   localparam int F7_W    = 7;
   localparam int F2_LSB  = 30;
   localparam int F2_W    = 2;
   localparam int LEN_LSB = 25;
   localparam int POS_LSB = 20;
   localparam int GRP_W   = 2;

   // register-operand field positions within the second source
   localparam int RS2_LEN_LSB = 5;
   localparam int RS2_POS_LSB = 0;

   // major opcodes and funct3 codes
   localparam logic [OPC_W-1:0] OPC_IMM   = 7'h5B;
   localparam logic [OPC_W-1:0] OPC_REG   = 7'h2B;
   localparam logic [F3_W-1:0]  F3_FIELD  = 3'h0;
   localparam logic [F3_W-1:0]  F3_BITS   = 3'h1;
   localparam logic [F3_W-1:0]  F3_ADDN   = 3'h2;
   localparam logic [F3_W-1:0]  F3_SUBN   = 3'h3;
   localparam logic [F3_W-1:0]  F3_REGOP  = 3'h3;

   // immediate-form two-bit subfield codes
   localparam logic [F2_W-1:0] F2_EXT_S  = 2'h0;
   localparam logic [F2_W-1:0] F2_EXT_U  = 2'h1;
   localparam logic [F2_W-1:0] F2_INSERT = 2'h2;
   localparam logic [F2_W-1:0] F2_CLEAR  = 2'h0;
   localparam logic [F2_W-1:0] F2_SET    = 2'h1;
   localparam logic [F2_W-1:0] F2_BITREV = 2'h3;
   localparam int F2_UNS_BIT   = 0;
   localparam int F2_ROUND_BIT = 1;

   // register-form function codes
   localparam logic [F7_W-1:0] F7_EXT_S   = 7'h18;
   localparam logic [F7_W-1:0] F7_EXT_U   = 7'h19;
   localparam logic [F7_W-1:0] F7_INSERT  = 7'h1A;
   localparam logic [F7_W-1:0] F7_CLEAR   = 7'h1C;
   localparam logic [F7_W-1:0] F7_SET     = 7'h1D;
   localparam logic [F7_W-1:0] F7_ROTATE  = 7'h20;
   localparam logic [F7_W-1:0] F7_FFS     = 7'h21;
   localparam logic [F7_W-1:0] F7_FLS     = 7'h22;
   localparam logic [F7_W-1:0] F7_CLB     = 7'h23;
   localparam logic [F7_W-1:0] F7_POPCNT  = 7'h24;
   localparam logic [F7_W-1:0] F7_ABS     = 7'h28;
   localparam logic [F7_W-1:0] F7_SLE_S   = 7'h29;
   localparam logic [F7_W-1:0] F7_SLE_U   = 7'h2A;
   localparam logic [F7_W-1:0] F7_MIN_S   = 7'h2B;
   localparam logic [F7_W-1:0] F7_MIN_U   = 7'h2C;
   localparam logic [F7_W-1:0] F7_MAX_S   = 7'h2D;
   localparam logic [F7_W-1:0] F7_MAX_U   = 7'h2E;
   localparam logic [F7_W-1:0] F7_EXTH_S  = 7'h2F;
   localparam logic [F7_W-1:0] F7_EXTH_Z  = 7'h30;
   localparam logic [F7_W-1:0] F7_EXTB_S  = 7'h31;
   localparam logic [F7_W-1:0] F7_EXTB_Z  = 7'h32;
   localparam logic [F7_W-1:0] F7_CLIP_SI = 7'h38;
   localparam logic [F7_W-1:0] F7_CLIP_UI = 7'h39;
   localparam logic [F7_W-1:0] F7_CLIP_SR = 7'h3A;
   localparam logic [F7_W-1:0] F7_CLIP_UR = 7'h3B;
   // accumulating normalize: 100 0xyz, z unsigned, y round, x subtract
   localparam logic [3:0] F7_ACC_HI   = 4'h8;
   localparam int F7_ACC_UNS_BIT   = 0;
   localparam int F7_ACC_ROUND_BIT = 1;
   localparam int F7_ACC_SUB_BIT   = 2;

   // datapath constants
   localparam cbalu_word_t  ALL_ONES  = 32'hFFFFFFFF;
   localparam cbalu_word_t  WORD_ONE  = 32'h00000001;
   localparam cbalu_word_t  WORD_ZERO = 32'h00000000;
   localparam cbalu_shamt_t TOP_BIT   = 5'h1F;
   localparam cbalu_count_t NONE_SET  = 6'h20;
   localparam int HALF_MSB = 15;
   localparam int BYTE_MSB = 7;

   typedef enum logic [4:0] {
      OP_NONE,
      OP_EXTRACT_S,
      OP_EXTRACT_U,
      OP_INSERT,
      OP_CLEAR,
      OP_SET,
      OP_BITREV,
      OP_ROTATE,
      OP_FIND_FIRST,
      OP_FIND_LAST,
      OP_LEAD_BITS,
      OP_POPCOUNT,
      OP_ABSOLUTE,
      OP_SLE_S,
      OP_SLE_U,
      OP_MIN_S,
      OP_MIN_U,
      OP_MAX_S,
      OP_MAX_U,
      OP_EXTH_S,
      OP_EXTH_Z,
      OP_EXTB_S,
      OP_EXTB_Z,
      OP_CLIP_S,
      OP_CLIP_U,
      OP_NORMALIZE
   } cbalu_op_e;

   typedef struct packed {
      logic        valid;
      cbalu_word_t instr;
      cbalu_word_t src_a;
      cbalu_word_t src_b;
      cbalu_word_t dst_old;
   } cbalu_req_s;

   typedef struct packed {
      logic        valid;
      logic        known;
      cbalu_word_t result;
   } cbalu_rsp_s;

endpackage

// ---- cbalu_bitrev.sv ----
module cbalu_bitrev (
   // operands
   input  wire cbalu_pkg::cbalu_word_t  src,
   input  wire cbalu_pkg::cbalu_shamt_t discard,
   input  wire logic [1:0]              group,
   // result
   output      cbalu_pkg::cbalu_word_t  result
);

   cbalu_pkg::cbalu_word_t shifted;

   assign shifted = src << discard;

   // group code 3 is not defined; it is handled as triplets
   always_comb
   begin
      int g;
      int k;
      int j;
      g = (group == 2'h0) ? 1 : ((group == 2'h1) ? 2 : 3);
      k = 0;
      j = 0;
      result = cbalu_pkg::WORD_ZERO;
      for (int i = 0; i < cbalu_pkg::XLEN; i++)
      begin
         k = i / g;
         j = i % g;
         // leftover low bits for triplets are dropped, top of result is zero
         if (k < cbalu_pkg::XLEN / g)
            result[i] = shifted[cbalu_pkg::XLEN - g * (k + 1) + j]; // [RL10]
      end
   end

endmodule // cbalu_bitrev

// ---- cbalu_core.sv ----
// Summary of operation
// (RL1) Extract field pos..min(pos+len,31); signed sign-extends top bit, else zero-extend.
// (RL2) Insert source bits into clamped field; other destination bits keep old value.
// (RL3) Clear clamped field to zero; other bits pass from first source.
// (RL4) Set clamped field to one; other bits pass from first source.
// (RL5) Index of lowest set bit; 32 for zero source.
// (RL6) Index of highest set bit; 32 for zero source.
// (RL7) Count bits equal to MSB from the top; zero source gives 0.
// (RL8) Count of one bits in the source.
// (RL9) Rotate first source right by second source amount.
// (RL10) Reverse in groups of 1, 2 or 3 bits after discarding top bits.
// (RL11) Absolute value; halfword and byte sign or zero extension.
// (RL12) Set 1 when first source <= second, signed or unsigned.
// (RL13) Minimum or maximum of the two sources, signed or unsigned.
// (RL14) Signed clip to -2^(n-1)..2^(n-1)-1; n of 0 gives -1..0.
// (RL15) Unsigned clip to 0..2^(n-1)-1 or register bound.
// (RL16) Register signed clip to -(bound+1)..bound.
// (RL17) Sum or difference shifted right, arithmetic or logical.
// (RL18) Rounding variants add 2^(shift-1) before the shift.
// (RL19) Accumulating forms use old destination and shift from second source low bits.
// (RL20) Immediate field forms: opcode 101 1011, funct3 000/001, subfield 31:30.
// (RL21) Register forms: opcode 010 1011, funct3 011, seven-bit function code.
// (RL22) Immediate normalize: funct3 010 add, 011 subtract, 31:30 selects variant.
// (RL23) Zero shift with rounding adds nothing.
module cbalu_core (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   // request from decode stage
   input  wire cbalu_pkg::cbalu_req_s req,
   // result towards register file
   output      cbalu_pkg::cbalu_rsp_s rsp
);

   // instruction fields
   logic [cbalu_pkg::OPC_W-1:0] opc;
   logic [cbalu_pkg::F3_W-1:0]  f3;
   logic [cbalu_pkg::F7_W-1:0]  f7;
   logic [cbalu_pkg::F2_W-1:0]  f2;
   cbalu_pkg::cbalu_shamt_t     imm_len;
   cbalu_pkg::cbalu_shamt_t     imm_pos;

   assign opc     = req.instr[cbalu_pkg::OPC_LSB +: cbalu_pkg::OPC_W];
   assign f3      = req.instr[cbalu_pkg::F3_LSB +: cbalu_pkg::F3_W];
   assign f7      = req.instr[cbalu_pkg::F7_LSB +: cbalu_pkg::F7_W];
   assign f2      = req.instr[cbalu_pkg::F2_LSB +: cbalu_pkg::F2_W];
   assign imm_len = req.instr[cbalu_pkg::LEN_LSB +: cbalu_pkg::SH_W];
   assign imm_pos = req.instr[cbalu_pkg::POS_LSB +: cbalu_pkg::SH_W];

   function automatic cbalu_pkg::cbalu_op_e decode_imm(input logic [cbalu_pkg::F3_W-1:0] fn3,
                                                      input logic [cbalu_pkg::F2_W-1:0] fn2);
      cbalu_pkg::cbalu_op_e op;
      op = cbalu_pkg::OP_NONE;
      if (fn3 == cbalu_pkg::F3_FIELD) // [RL20]
      begin
         if (fn2 == cbalu_pkg::F2_EXT_S)
            op = cbalu_pkg::OP_EXTRACT_S;
         else if (fn2 == cbalu_pkg::F2_EXT_U)
            op = cbalu_pkg::OP_EXTRACT_U;
         else if (fn2 == cbalu_pkg::F2_INSERT)
            op = cbalu_pkg::OP_INSERT;
      end
      else if (fn3 == cbalu_pkg::F3_BITS) // [RL20]
      begin
         if (fn2 == cbalu_pkg::F2_CLEAR)
            op = cbalu_pkg::OP_CLEAR;
         else if (fn2 == cbalu_pkg::F2_SET)
            op = cbalu_pkg::OP_SET;
         else if (fn2 == cbalu_pkg::F2_BITREV)
            op = cbalu_pkg::OP_BITREV;
      end
      else if (fn3 == cbalu_pkg::F3_ADDN || fn3 == cbalu_pkg::F3_SUBN) // [RL22]
         op = cbalu_pkg::OP_NORMALIZE;
      return op;
   endfunction

   function automatic cbalu_pkg::cbalu_op_e decode_reg(input logic [cbalu_pkg::F7_W-1:0] fn7);
      cbalu_pkg::cbalu_op_e op;
      op = cbalu_pkg::OP_NONE;
      // [RL21]
      unique case (fn7)
         cbalu_pkg::F7_EXT_S:   op = cbalu_pkg::OP_EXTRACT_S;
         cbalu_pkg::F7_EXT_U:   op = cbalu_pkg::OP_EXTRACT_U;
         cbalu_pkg::F7_INSERT:  op = cbalu_pkg::OP_INSERT;
         cbalu_pkg::F7_CLEAR:   op = cbalu_pkg::OP_CLEAR;
         cbalu_pkg::F7_SET:     op = cbalu_pkg::OP_SET;
         cbalu_pkg::F7_ROTATE:  op = cbalu_pkg::OP_ROTATE;
         cbalu_pkg::F7_FFS:     op = cbalu_pkg::OP_FIND_FIRST;
         cbalu_pkg::F7_FLS:     op = cbalu_pkg::OP_FIND_LAST;
         cbalu_pkg::F7_CLB:     op = cbalu_pkg::OP_LEAD_BITS;
         cbalu_pkg::F7_POPCNT:  op = cbalu_pkg::OP_POPCOUNT;
         cbalu_pkg::F7_ABS:     op = cbalu_pkg::OP_ABSOLUTE;
         cbalu_pkg::F7_SLE_S:   op = cbalu_pkg::OP_SLE_S;
         cbalu_pkg::F7_SLE_U:   op = cbalu_pkg::OP_SLE_U;
         cbalu_pkg::F7_MIN_S:   op = cbalu_pkg::OP_MIN_S;
         cbalu_pkg::F7_MIN_U:   op = cbalu_pkg::OP_MIN_U;
         cbalu_pkg::F7_MAX_S:   op = cbalu_pkg::OP_MAX_S;
         cbalu_pkg::F7_MAX_U:   op = cbalu_pkg::OP_MAX_U;
         cbalu_pkg::F7_EXTH_S:  op = cbalu_pkg::OP_EXTH_S;
         cbalu_pkg::F7_EXTH_Z:  op = cbalu_pkg::OP_EXTH_Z;
         cbalu_pkg::F7_EXTB_S:  op = cbalu_pkg::OP_EXTB_S;
         cbalu_pkg::F7_EXTB_Z:  op = cbalu_pkg::OP_EXTB_Z;
         cbalu_pkg::F7_CLIP_SI: op = cbalu_pkg::OP_CLIP_S;
         cbalu_pkg::F7_CLIP_UI: op = cbalu_pkg::OP_CLIP_U;
         cbalu_pkg::F7_CLIP_SR: op = cbalu_pkg::OP_CLIP_S;
         cbalu_pkg::F7_CLIP_UR: op = cbalu_pkg::OP_CLIP_U;
         default:
            if (fn7[cbalu_pkg::F7_W-1:3] == cbalu_pkg::F7_ACC_HI)
               op = cbalu_pkg::OP_NORMALIZE;
      endcase
      return op;
   endfunction

   // top of the field, clamped at bit 31
   function automatic cbalu_pkg::cbalu_shamt_t field_top(input cbalu_pkg::cbalu_shamt_t len,
                                                        input cbalu_pkg::cbalu_shamt_t pos);
      logic [cbalu_pkg::SH_W:0] sum;
      sum = {1'b0, len} + {1'b0, pos};
      return (sum > {1'b0, cbalu_pkg::TOP_BIT}) ? cbalu_pkg::TOP_BIT : sum[cbalu_pkg::SH_W-1:0];
   endfunction

   function automatic cbalu_pkg::cbalu_word_t field_mask(input cbalu_pkg::cbalu_shamt_t top,
                                                        input cbalu_pkg::cbalu_shamt_t pos);
      return (cbalu_pkg::ALL_ONES << pos) & (cbalu_pkg::ALL_ONES >> (cbalu_pkg::TOP_BIT - top));
   endfunction

   function automatic cbalu_pkg::cbalu_word_t round_const(input cbalu_pkg::cbalu_shamt_t sh);
      // no half-LSB exists for a zero shift
      return (sh == '0) ? cbalu_pkg::WORD_ZERO : (cbalu_pkg::WORD_ONE << (sh - 5'h01)); // [RL23]
   endfunction

   function automatic cbalu_pkg::cbalu_word_t normalize(input cbalu_pkg::cbalu_word_t a,
                                                       input cbalu_pkg::cbalu_word_t b,
                                                       input cbalu_pkg::cbalu_shamt_t sh,
                                                       input logic sub,
                                                       input logic rnd,
                                                       input logic uns);
      cbalu_pkg::cbalu_word_t t;
      t = sub ? (a - b) : (a + b); // [RL17]
      if (rnd)
         t = t + round_const(sh); // [RL18]
      return uns ? (t >> sh) : cbalu_pkg::cbalu_word_t'($signed(t) >>> sh); // [RL17]
   endfunction

   function automatic cbalu_pkg::cbalu_word_t clip(input cbalu_pkg::cbalu_word_t x,
                                                  input cbalu_pkg::cbalu_word_t hi,
                                                  input cbalu_pkg::cbalu_word_t lo);
      cbalu_pkg::cbalu_word_t r;
      if ($signed(x) <= $signed(lo))
         r = lo;
      else if ($signed(x) >= $signed(hi))
         r = hi;
      else
         r = x;
      return r;
   endfunction

   function automatic cbalu_pkg::cbalu_count_t find_first(input cbalu_pkg::cbalu_word_t x);
      cbalu_pkg::cbalu_count_t r;
      r = cbalu_pkg::NONE_SET;
      for (int i = cbalu_pkg::XLEN - 1; i >= 0; i--)
         if (x[i])
            r = cbalu_pkg::cbalu_count_t'(i);
      return r;
   endfunction

   function automatic cbalu_pkg::cbalu_count_t find_last(input cbalu_pkg::cbalu_word_t x);
      cbalu_pkg::cbalu_count_t r;
      r = cbalu_pkg::NONE_SET;
      for (int i = 0; i < cbalu_pkg::XLEN; i++)
         if (x[i])
            r = cbalu_pkg::cbalu_count_t'(i);
      return r;
   endfunction

   function automatic cbalu_pkg::cbalu_count_t lead_bits(input cbalu_pkg::cbalu_word_t x);
      cbalu_pkg::cbalu_count_t r;
      logic run;
      r = '0;
      run = (x != cbalu_pkg::WORD_ZERO);
      for (int i = cbalu_pkg::XLEN - 1; i >= 0; i--)
      begin
         run = run && (x[i] == x[cbalu_pkg::XLEN-1]);
         if (run)
            r = r + 6'h01;
      end
      return r;
   endfunction

   function automatic cbalu_pkg::cbalu_count_t pop_count(input cbalu_pkg::cbalu_word_t x);
      cbalu_pkg::cbalu_count_t r;
      r = '0;
      for (int i = 0; i < cbalu_pkg::XLEN; i++)
         r = r + cbalu_pkg::cbalu_count_t'(x[i]);
      return r;
   endfunction

   // decode
   logic                   is_imm;
   logic                   is_reg;
   cbalu_pkg::cbalu_op_e   op;
   cbalu_pkg::cbalu_shamt_t len;
   cbalu_pkg::cbalu_shamt_t pos;

   assign is_imm = (opc == cbalu_pkg::OPC_IMM); // [RL20] [RL22]
   assign is_reg = (opc == cbalu_pkg::OPC_REG) && (f3 == cbalu_pkg::F3_REGOP); // [RL21]
   assign op     = is_imm ? decode_imm(f3, f2) :
                   (is_reg ? decode_reg(f7) : cbalu_pkg::OP_NONE);
   // register forms carry length and position in the second source
   assign len    = is_reg ? req.src_b[cbalu_pkg::RS2_LEN_LSB +: cbalu_pkg::SH_W] : imm_len; // [RL1]
   assign pos    = is_reg ? req.src_b[cbalu_pkg::RS2_POS_LSB +: cbalu_pkg::SH_W] : imm_pos; // [RL1]

   // field operations
   cbalu_pkg::cbalu_shamt_t top;
   cbalu_pkg::cbalu_shamt_t width_m1;
   cbalu_pkg::cbalu_shamt_t overflow;
   cbalu_pkg::cbalu_word_t  mask;
   cbalu_pkg::cbalu_word_t  fld;
   cbalu_pkg::cbalu_word_t  sign_fill;
   cbalu_pkg::cbalu_word_t  ins_val;
   logic [cbalu_pkg::SH_W:0] len_pos_sum;

   assign top         = field_top(len, pos);
   assign mask        = field_mask(top, pos);
   assign width_m1    = top - pos;
   assign fld         = (req.src_a & mask) >> pos; // [RL1]
   assign sign_fill   = req.src_a[top] ? (cbalu_pkg::ALL_ONES << width_m1) << 1 : '0; // [RL1]
   assign len_pos_sum = {1'b0, len} + {1'b0, pos};
   // when the field is clamped the source bits below the overflow amount are dropped
   assign overflow    = (len_pos_sum > {1'b0, cbalu_pkg::TOP_BIT}) ?
                        cbalu_pkg::cbalu_shamt_t'(len_pos_sum - {1'b0, cbalu_pkg::TOP_BIT}) : '0;
   assign ins_val     = (req.dst_old & ~mask) | (((req.src_a >> overflow) << pos) & mask); // [RL2]

   // clip bounds
   cbalu_pkg::cbalu_word_t clip_hi;
   cbalu_pkg::cbalu_word_t clip_lo;
   cbalu_pkg::cbalu_word_t imm_hi;

   assign imm_hi  = (imm_pos == '0) ? '0 :
                    ((cbalu_pkg::WORD_ONE << (imm_pos - 5'h01)) - cbalu_pkg::WORD_ONE); // [RL14]
   assign clip_hi = (f7 == cbalu_pkg::F7_CLIP_SR || f7 == cbalu_pkg::F7_CLIP_UR) ?
                    req.src_b : imm_hi; // [RL15] [RL16]
   // -(hi+1) is the complement of hi; for n of 0 this gives -1
   assign clip_lo = (op == cbalu_pkg::OP_CLIP_U) ? '0 : ~clip_hi; // [RL14] [RL15] [RL16]

   // normalize operands
   logic                    norm_sub;
   logic                    norm_rnd;
   logic                    norm_uns;
   cbalu_pkg::cbalu_word_t  norm_a;
   cbalu_pkg::cbalu_word_t  norm_b;
   cbalu_pkg::cbalu_shamt_t norm_sh;

   assign norm_sub = is_reg ? f7[cbalu_pkg::F7_ACC_SUB_BIT] : (f3 == cbalu_pkg::F3_SUBN);
   assign norm_rnd = is_reg ? f7[cbalu_pkg::F7_ACC_ROUND_BIT] : f2[cbalu_pkg::F2_ROUND_BIT];
   assign norm_uns = is_reg ? f7[cbalu_pkg::F7_ACC_UNS_BIT] : f2[cbalu_pkg::F2_UNS_BIT];
   assign norm_a   = is_reg ? req.dst_old : req.src_a; // [RL19]
   assign norm_b   = is_reg ? req.src_a : req.src_b; // [RL19]
   assign norm_sh  = is_reg ? req.src_b[cbalu_pkg::RS2_POS_LSB +: cbalu_pkg::SH_W] : imm_len; // [RL19]

   cbalu_pkg::cbalu_word_t bitrev_val;

   cbalu_bitrev u_bitrev (
      .src     (req.src_a),
      .discard (imm_pos),
      .group   (imm_len[cbalu_pkg::GRP_W-1:0]),
      .result  (bitrev_val)
   );

   // comparisons
   logic le_s;
   logic le_u;
   logic lt_s;
   logic lt_u;

   assign le_s = $signed(req.src_a) <= $signed(req.src_b);
   assign le_u = req.src_a <= req.src_b;
   assign lt_s = $signed(req.src_a) < $signed(req.src_b);
   assign lt_u = req.src_a < req.src_b;

   cbalu_pkg::cbalu_word_t next_result;

   always_comb
   begin
      next_result = cbalu_pkg::WORD_ZERO;
      unique case (op)
         cbalu_pkg::OP_NONE:       next_result = cbalu_pkg::WORD_ZERO;
         cbalu_pkg::OP_EXTRACT_S:  next_result = fld | sign_fill; // [RL1]
         cbalu_pkg::OP_EXTRACT_U:  next_result = fld; // [RL1]
         cbalu_pkg::OP_INSERT:     next_result = ins_val; // [RL2]
         cbalu_pkg::OP_CLEAR:      next_result = req.src_a & ~mask; // [RL3]
         cbalu_pkg::OP_SET:        next_result = req.src_a | mask; // [RL4]
         cbalu_pkg::OP_BITREV:     next_result = bitrev_val; // [RL10]
         cbalu_pkg::OP_ROTATE:     next_result = (req.src_a >> req.src_b[cbalu_pkg::SH_W-1:0]) |
                                                 (req.src_a << (cbalu_pkg::SH_W'(0) -
                                                  req.src_b[cbalu_pkg::SH_W-1:0])); // [RL9]
         cbalu_pkg::OP_FIND_FIRST: next_result = cbalu_pkg::cbalu_word_t'(find_first(req.src_a)); // [RL5]
         cbalu_pkg::OP_FIND_LAST:  next_result = cbalu_pkg::cbalu_word_t'(find_last(req.src_a)); // [RL6]
         cbalu_pkg::OP_LEAD_BITS:  next_result = cbalu_pkg::cbalu_word_t'(lead_bits(req.src_a)); // [RL7]
         cbalu_pkg::OP_POPCOUNT:   next_result = cbalu_pkg::cbalu_word_t'(pop_count(req.src_a)); // [RL8]
         cbalu_pkg::OP_ABSOLUTE:   next_result = req.src_a[cbalu_pkg::XLEN-1] ? -req.src_a : req.src_a; // [RL11]
         cbalu_pkg::OP_SLE_S:      next_result = cbalu_pkg::cbalu_word_t'(le_s); // [RL12]
         cbalu_pkg::OP_SLE_U:      next_result = cbalu_pkg::cbalu_word_t'(le_u); // [RL12]
         cbalu_pkg::OP_MIN_S:      next_result = lt_s ? req.src_a : req.src_b; // [RL13]
         cbalu_pkg::OP_MIN_U:      next_result = lt_u ? req.src_a : req.src_b; // [RL13]
         cbalu_pkg::OP_MAX_S:      next_result = lt_s ? req.src_b : req.src_a; // [RL13]
         cbalu_pkg::OP_MAX_U:      next_result = lt_u ? req.src_b : req.src_a; // [RL13]
         cbalu_pkg::OP_EXTH_S:     next_result = cbalu_pkg::cbalu_word_t'(
                                                 $signed(req.src_a[cbalu_pkg::HALF_MSB:0])); // [RL11]
         cbalu_pkg::OP_EXTH_Z:     next_result = cbalu_pkg::cbalu_word_t'(req.src_a[cbalu_pkg::HALF_MSB:0]); // [RL11]
         cbalu_pkg::OP_EXTB_S:     next_result = cbalu_pkg::cbalu_word_t'(
                                                 $signed(req.src_a[cbalu_pkg::BYTE_MSB:0])); // [RL11]
         cbalu_pkg::OP_EXTB_Z:     next_result = cbalu_pkg::cbalu_word_t'(req.src_a[cbalu_pkg::BYTE_MSB:0]); // [RL11]
         cbalu_pkg::OP_CLIP_S:     next_result = clip(req.src_a, clip_hi, clip_lo); // [RL14] [RL16]
         cbalu_pkg::OP_CLIP_U:     next_result = clip(req.src_a, clip_hi, clip_lo); // [RL15]
         cbalu_pkg::OP_NORMALIZE:  next_result = normalize(norm_a, norm_b, norm_sh,
                                                           norm_sub, norm_rnd, norm_uns); // [RL17] [RL19]
      endcase
   end

   // one register stage; result is held until the next accepted request
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rsp <= '0;
      else
      begin
         rsp.valid <= req.valid;
         if (req.valid)
         begin
            rsp.known  <= (op != cbalu_pkg::OP_NONE);
            rsp.result <= next_result;
         end
      end
   end

endmodule // cbalu_core

// ---- cbalu_core_sva.sv ----
module cbalu_core_chk (
   // clock, reset and watched ports
   input wire logic                  clk,
   input wire logic                  sys_rst,
   input wire cbalu_pkg::cbalu_req_s req,
   input wire cbalu_pkg::cbalu_rsp_s rsp
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire cbalu_pkg::cbalu_word_t a      = req.src_a;
   wire cbalu_pkg::cbalu_word_t b      = req.src_b;
   wire logic [4:0]             sh     = req.src_b[4:0];
   wire logic [6:0]             f7     = req.instr[31:25];
   wire logic                   rg_op  = req.valid && req.instr[6:0] == 7'h2B && req.instr[14:12] == 3'h3;
   wire logic                   imm_op = req.valid && req.instr[6:0] == 7'h5B;
   pop_count_a: assert property (rg_op && f7 == 7'h24 |=>
      rsp.result == 32'($countones($past(a)))) else $error("popcount wrong");
   rotate_right_a: assert property (rg_op && f7 == 7'h20 |=>
      rsp.result == ($past(a) >> $past(sh) | $past(a) << (6'h20 - $past(sh)))) else $error("rotate wrong");
   abs_value_a: assert property (rg_op && f7 == 7'h28 |=>
      rsp.result == ($signed($past(a)) < 0 ? -$past(a) : $past(a))) else $error("abs wrong");
   le_signed_a: assert property (rg_op && f7 == 7'h29 |=>
      rsp.result == 32'($signed($past(a)) <= $signed($past(b)))) else $error("sle wrong");
   min_unsigned_a: assert property (rg_op && f7 == 7'h2C |=>
      rsp.result == ($past(a) < $past(b) ? $past(a) : $past(b))) else $error("minu wrong");
   max_signed_a: assert property (rg_op && f7 == 7'h2D |=>
      rsp.result == ($signed($past(a)) < $signed($past(b)) ? $past(b) : $past(a))) else $error("max wrong");
   unknown_code_a: assert property (imm_op && req.instr[14:12] == 3'h0 && f7[6:5] == 2'h3 |=>
      rsp.valid && !rsp.known && rsp.result == '0) else $error("unknown code answered");
   known_reg_a: assert property (rg_op && f7 == 7'h18 |=> rsp.valid && rsp.known)
      else $error("register form not recognised");
   cover property (rg_op && f7 == 7'h46);
   cover property (imm_op && req.instr[14:12] == 3'h1 && f7[6:5] == 2'h3);
   cover property (req.valid ##1 rsp.valid && rsp.known);
endmodule // cbalu_core_chk
bind cbalu_core cbalu_core_chk u_chk (.clk(clk), .sys_rst(sys_rst), .req(req), .rsp(rsp));

// ---- cbalu_wb_model.sv ----
module cbalu_wb_model (
   // result in, written-back word out; unknown codes never reach the file
   input wire logic                  clk,
   input wire cbalu_pkg::cbalu_rsp_s rsp,
   output     cbalu_pkg::cbalu_word_t wb
);
   always_ff @(posedge clk)
      if (rsp.valid && rsp.known)
         wb <= rsp.result;
endmodule // cbalu_wb_model

// ---- custom_bitmanip_alu_ops_test.sv ----
module custom_bitmanip_alu_ops_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int IMM = int'(cbalu_pkg::OPC_IMM), REG = int'(cbalu_pkg::OPC_REG);
   logic                   clk = 1'b0;
   logic                   sys_rst = 1'b1;
   cbalu_pkg::cbalu_req_s  req = '0;
   cbalu_pkg::cbalu_rsp_s  rsp;
   cbalu_pkg::cbalu_word_t wb;
   int                     fails = 0, tests_run = 0, cycles = 0;
   always #25 clk = ~clk;
   cbalu_core u_dut (.clk(clk), .sys_rst(sys_rst), .req(req), .rsp(rsp));
   cbalu_wb_model u_wb (.clk(clk), .rsp(rsp), .wb(wb));
   function automatic cbalu_pkg::cbalu_word_t enc(input int hi, mid, f3, opc);
      return {7'(hi), 5'(mid), 5'h00, 3'(f3), 5'h00, 7'(opc)};
   endfunction
   task automatic check(input cbalu_pkg::cbalu_word_t seen, exp);
      tests_run++;
      if (seen !== exp)
         $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
      fails += int'(seen !== exp);
   endtask
   // one request, then its answer one edge later; valid dropped so answers stay one per request
   task automatic op(input cbalu_pkg::cbalu_word_t i, sa, e, sb = '0, sd = '0, input logic k = 1'b1);
      @(posedge clk);
      req <= '{1'b1, i, sa, sb, sd};
      @(posedge clk);
      req.valid <= 1'b0;
      #1;
      check(32'({rsp.valid, rsp.known}), 32'({1'b1, k}));
      check(rsp.result, e);
   endtask
   task automatic t_bits();
      op(enc(7'h03, 8, 0, IMM), 32'hF00, 32'hFFFFFFFF);
      op(enc(7'h23, 8, 0, IMM), 32'hF00, 32'hF);
      op(enc(7'h18, 0, 3, REG), 32'hF00, 32'hFFFFFFFF, 32'h68);
      op(enc(7'h43, 4, 0, IMM), 32'h5, 32'hFFFFFF5F, '0, 32'hFFFFFFFF);
      op(enc(7'h07, 8, 1, IMM), 32'hFFFFFFFF, 32'hFFFF00FF);
      op(enc(7'h27, 8, 1, IMM), '0, 32'hFF00);
      op(enc(7'h21, 0, 3, REG), '0, 32'h20);
      op(enc(7'h22, 0, 3, REG), 32'h1, '0);
      op(enc(7'h23, 0, 3, REG), 32'hF0000000, 32'h4);
      op(enc(7'h24, 0, 3, REG), 32'hF0F0000F, 32'hC);
      op(enc(7'h20, 0, 3, REG), 32'h1, 32'h10000000, 32'h4);
      op(enc(7'h62, 4, 1, IMM), 32'hC64A5933, 32'h216B244B);
      op(enc(7'h60, 0, 0, IMM), 32'h1, '0, '0, '0, 1'b0);
   endtask
   task automatic t_arith();
      op(enc(7'h28, 0, 3, REG), 32'hFFFFFFFB, 32'h5);
      op(enc(7'h2F, 0, 3, REG), 32'h18000, 32'hFFFF8000);
      op(enc(7'h32, 0, 3, REG), 32'hFFFFFF80, 32'h80);
      op(enc(7'h29, 0, 3, REG), 32'hFFFFFFFF, 32'h1, 32'h1);
      op(enc(7'h2C, 0, 3, REG), 32'hFFFFFFFF, 32'h1, 32'h1);
      op(enc(7'h2D, 0, 3, REG), 32'hFFFFFFFF, 32'h1, 32'h1);
      op(enc(7'h2A, 0, 3, REG), 32'hFFFFFFFF, '0, 32'h1);
      op(enc(7'h2E, 0, 3, REG), 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h1);
      op(enc(7'h38, 0, 3, REG), 32'h5, '0);
      op(enc(7'h38, 4, 3, REG), 32'hFFFFFF00, 32'hFFFFFFF8);
      op(enc(7'h39, 4, 3, REG), 32'h64, 32'h7);
      op(enc(7'h3B, 0, 3, REG), 32'h20, 32'hA, 32'hA);
      op(enc(7'h3A, 0, 3, REG), 32'hFFFFFF00, 32'hFFFFFFF5, 32'hA);
      op(enc(7'h04, 0, 2, IMM), 32'h80000000, 32'hF8000000);
      op(enc(7'h24, 0, 2, IMM), 32'h80000000, 32'h8000000);
      op(enc(7'h42, 0, 2, IMM), 32'h7, 32'h2);
      op(enc(7'h60, 0, 3, IMM), 32'h7, 32'h7);
      op(enc(7'h46, 0, 3, REG), 32'h1, 32'h8, 32'h1, 32'h10);
   endtask
   task automatic end_sim();
      fails += int'(cycles > 500);
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ceiling far above the 83 cycles the sequence needs
   always @(posedge clk)
      if (++cycles > 500)
         end_sim();
   initial
   begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      t_bits();
      t_arith();
      @(posedge clk);
      #1;
      check(wb, 32'h8);
      end_sim();
   end
endmodule // custom_bitmanip_alu_ops_test
